// File: hdl/exception_priority_unit.sv
// Exception priority, flush and commit logic of a six-stage core.
// Assumes the pipeline reports pending exception bits per stage and the
// oldest instruction's conditions at writeback; registers over APB.
// How it works
// - Taking an exception masks interrupts, jumps to vector; all but debug ones set kernel level.
// - Restart address is faulting pc, or branch pc with delay flag set.
// - Data bus errors may also arrive imprecisely; they are held pending until taken.
// - Detection kills the causing and all younger instructions and inhibits stalls.
// - Commit at writeback writes state, redirects pc, clears earlier bits.
// - Older ones complete; restart goes to normal, error or debug register.
// - Program order: an older later exception kills a younger excepting one.
// - Of simultaneous conditions only the highest priority one is taken.
// - Top order: cold, warm reset, single step, debug irq, NMI, interrupt.
// - Debug irq comes from the external pin or the debug break bit.
// - NMI is taken on the rising edge of its input only.
// - Fetch order: protection, instr break, address, parity, ECC, bus.
// - Fetch address error for misalignment or user fetch of kernel space.
// - Coprocessor unusable and DSP disabled outrank reserved instruction.
// - Forbidden base register write ranks just below execution exceptions.
// - Data order: protection, break, load, store, parity, ECC, bus, breaks.
// - Load and store address errors are reported as separate types.
// - Hardware sets error level after cold reset, warm reset or NMI.
// - Return jumps to restart, clears error level, then exception level.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module exception_priority_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous pins
  input wire logic cold_reset_in_n,
  input wire logic warm_reset_in_n,
  input wire logic nmi_in,
  input wire logic ext_debug_irq_in,
  input wire logic [5:0] hw_int_in,
  // Pipeline stage status, bit 5 is writeback
  input wire logic [5:0] stage_exc_pending,
  // Oldest instruction at writeback
  input wire logic wb_valid,
  input wire logic [31:0] wb_pc,
  input wire logic wb_in_slot,
  input wire logic [31:0] wb_branch_pc,
  input wire logic wb_eret,
  input wire logic wb_deret,
  // Fetch side conditions
  input wire logic wb_fetch_prot,
  input wire logic wb_debug_instr_break,
  input wire logic [31:0] wb_fetch_addr,
  input wire logic wb_imem_parity,
  input wire logic wb_imem_ecc,
  input wire logic wb_fetch_bus_error,
  // Execution conditions
  input wire logic wb_cop_unusable,
  input wire logic wb_dsp_disabled,
  input wire logic wb_reserved_instr,
  input wire logic wb_exc_base_write,
  input wire logic mpu_exc_base_deny,
  // Data side conditions
  input wire logic wb_data_prot,
  input wire logic wb_debug_store_break,
  input wire logic wb_is_load,
  input wire logic wb_is_store,
  input wire logic [31:0] wb_data_addr,
  input wire logic [1:0] wb_data_size,
  input wire logic wb_dmem_parity,
  input wire logic wb_dmem_ecc,
  input wire logic wb_data_bus_error,
  input wire logic wb_debug_load_break,
  input wire logic wb_complex_breakpoint,
  input wire logic late_bus_error,
  // Commit results
  output logic [5:0] kill_mask,
  output logic stall_inhibit,
  output logic clear_exc,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic [4:0] exc_code,
  output logic kernel_mode,
  output logic debug_mode
);
  import exc_pkg::*;

  core_state_t st_reg;
  core_state_t st_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [9:0] pin_level;
  logic [9:0] pin_rise;
  cond_vec_t cond;
  logic take;
  logic [4:0] code;
  exc_class_t cls;
  logic user_now;
  logic int_req;
  logic [31:0] restart_addr;
  logic [31:0] rd;
  logic hit;
  logic wr;
  logic acc;

  function automatic logic misaligned(input logic [31:0] a,
                                      input logic [1:0] size);
    return (size == `SZ_HALF && a[0]) ||
           (size == `SZ_WORD && a[1:0] != 2'h0);
  endfunction

  function automatic logic [4:0] first_set(input cond_vec_t v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = `N_COND - 1; i >= 0; i--) begin
      if (v[i]) idx = 5'(i);
    end
    return idx;
  endfunction

  function automatic exc_class_t class_of(input logic [4:0] idx);
    case (idx)
      5'(`PRI_COLD), 5'(`PRI_WARM), 5'(`PRI_NMI), 5'(`PRI_IMEM_PAR),
      5'(`PRI_IMEM_ECC), 5'(`PRI_DMEM_PAR), 5'(`PRI_DMEM_ECC): begin
        return CLS_ERROR;
      end
      5'(`PRI_STEP), 5'(`PRI_DBG_IRQ), 5'(`PRI_INSTR_BRK),
      5'(`PRI_DATA_BRK), 5'(`PRI_LOAD_BRK), 5'(`PRI_COMPLEX_BRK): begin
        return CLS_DEBUG;
      end
      default: return CLS_GENERAL;
    endcase
  endfunction

  // Pins: cold, warm, debug irq, nmi, six interrupts
  exc_pin_sync #(
    .WIDTH(10),
    .RST_VAL(10'h003)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .pins_in({hw_int_in, nmi_in, ext_debug_irq_in, warm_reset_in_n,
              cold_reset_in_n}),
    .level(pin_level),
    .rise(pin_rise)
  );

  // Condition vector and priority encoder
  always_comb begin
    user_now = st_reg.user_mode_bit && !st_reg.exception_level_bit &&
               !st_reg.error_level_bit && !st_reg.debug_mode;
    int_req = |({pin_level[9:4], st_reg.sw_int} & st_reg.int_mask) &&
              st_reg.int_enable && !st_reg.exception_level_bit &&
              !st_reg.error_level_bit && !st_reg.debug_mode;
    cond = '0;
    cond[`PRI_COLD] = !pin_level[0];
    cond[`PRI_WARM] = !pin_level[1];
    cond[`PRI_STEP] = wb_valid && st_reg.single_step && !st_reg.debug_mode;
    cond[`PRI_DBG_IRQ] = wb_valid && !st_reg.debug_mode &&
                         (pin_level[2] || st_reg.debug_break_bit);
    cond[`PRI_NMI] = wb_valid && st_reg.nmi_pend;
    cond[`PRI_INT] = wb_valid && int_req;
    cond[`PRI_FETCH_PROT] = wb_valid && wb_fetch_prot;
    cond[`PRI_INSTR_BRK] = wb_valid && wb_debug_instr_break;
    cond[`PRI_FETCH_ADDR] = wb_valid && (misaligned(wb_fetch_addr, `SZ_HALF)
                            || (user_now && wb_fetch_addr[31]));
    cond[`PRI_IMEM_PAR] = wb_valid && wb_imem_parity;
    cond[`PRI_IMEM_ECC] = wb_valid && wb_imem_ecc;
    cond[`PRI_FETCH_BUS] = wb_valid && wb_fetch_bus_error;
    cond[`PRI_COP_UNUSABLE] = wb_valid &&
                              (wb_cop_unusable || wb_dsp_disabled);
    cond[`PRI_RESERVED] = wb_valid && wb_reserved_instr;
    cond[`PRI_EXEC_PROT] = wb_valid && wb_exc_base_write &&
                           mpu_exc_base_deny;
    cond[`PRI_DATA_PROT] = wb_valid && wb_data_prot;
    cond[`PRI_DATA_BRK] = wb_valid && wb_debug_store_break;
    cond[`PRI_LOAD_ADDR] = wb_valid && wb_is_load &&
                           (misaligned(wb_data_addr, wb_data_size) ||
                            (user_now && wb_data_addr[31]));
    cond[`PRI_STORE_ADDR] = wb_valid && wb_is_store &&
                            (misaligned(wb_data_addr, wb_data_size) ||
                             (user_now && wb_data_addr[31]));
    cond[`PRI_DMEM_PAR] = wb_valid && wb_dmem_parity;
    cond[`PRI_DMEM_ECC] = wb_valid && wb_dmem_ecc;
    cond[`PRI_DATA_BUS] = wb_valid &&
                          (wb_data_bus_error || st_reg.late_bus_err);
    cond[`PRI_LOAD_BRK] = wb_valid && wb_debug_load_break;
    cond[`PRI_COMPLEX_BRK] = wb_valid && wb_complex_breakpoint;
    take = |cond;
    code = first_set(cond);
    cls = class_of(code);
    restart_addr = wb_in_slot ? wb_branch_pc : wb_pc;
  end

  // APB read decode
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `OFS_STATUS: begin
        rd[`ST_IE] = st_reg.int_enable;
        rd[`ST_EXCL] = st_reg.exception_level_bit;
        rd[`ST_ERRL] = st_reg.error_level_bit;
        rd[`ST_UM] = st_reg.user_mode_bit;
        rd[`ST_DEBUG] = st_reg.debug_mode;
        rd[`ST_KERNEL] = st_reg.kernel_mode;
      end
      `OFS_CAUSE: begin
        rd[`CA_CODE_LO +: 5] = st_reg.cause_code;
        rd[`CA_SWINT_LO +: 2] = st_reg.sw_int;
        rd[`CA_BDELAY] = st_reg.branch_delay_flag;
      end
      `OFS_RESTART: rd = st_reg.restart_pc;
      `OFS_ERR_RESTART: rd = st_reg.error_restart_pc;
      `OFS_DBG_RESTART: rd = st_reg.debug_restart_pc;
      `OFS_EXC_BASE: rd = st_reg.exception_base_reg;
      `OFS_DEBUG_CTRL: begin
        rd[`DC_BREAK] = st_reg.debug_break_bit;
        rd[`DC_STEP] = st_reg.single_step;
      end
      `OFS_INT_MASK: rd[7:0] = st_reg.int_mask;
      default: hit = 1'b0;
    endcase
    // Answer one cycle after setup: zero wait states
    pready_next = psel && !penable;
    prdata_next = pready_next ? rd : 32'h0000_0000;
    pslverr_next = pready_next && !hit;
    acc = psel && penable && pready_reg;
    wr = acc && pwrite;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Core state: software writes, then hardware events over all of them but a break bit set
  always_comb begin
    st_next = st_reg;
    st_next.redirect_valid = 1'b0;
    st_next.clear_exc = 1'b0;
    if (wr) begin
      case (paddr)
        `OFS_STATUS: begin
          st_next.int_enable = pwdata[`ST_IE];
          st_next.exception_level_bit = pwdata[`ST_EXCL];
          st_next.error_level_bit = pwdata[`ST_ERRL];
          st_next.user_mode_bit = pwdata[`ST_UM];
        end
        `OFS_CAUSE: st_next.sw_int = pwdata[`CA_SWINT_LO +: 2];
        `OFS_RESTART: st_next.restart_pc = pwdata;
        `OFS_ERR_RESTART: st_next.error_restart_pc = pwdata;
        `OFS_DBG_RESTART: st_next.debug_restart_pc = pwdata;
        `OFS_EXC_BASE: st_next.exception_base_reg = pwdata;
        `OFS_DEBUG_CTRL: st_next.single_step = pwdata[`DC_STEP];
        `OFS_INT_MASK: st_next.int_mask = pwdata[7:0];
        default: ;
      endcase
    end
    // Pending events: a new event wins over the clear by taking
    st_next.nmi_pend = (st_reg.nmi_pend &&
                        !(take && code == 5'(`PRI_NMI))) ||
                       pin_rise[3];
    st_next.late_bus_err = (st_reg.late_bus_err &&
                            !(take && code == 5'(`PRI_DATA_BUS))) ||
                           late_bus_error;
    // Kill the oldest pending stage and all younger, keep older ones
    st_next.kill_mask[5] = stage_exc_pending[5];
    for (int i = 4; i >= 0; i--) begin
      st_next.kill_mask[i] = st_next.kill_mask[i + 1] ||
                             stage_exc_pending[i];
    end
    st_next.stall_inhibit = take || |stage_exc_pending;
    if (take) begin
      st_next.kill_mask = 6'h3F;
      st_next.clear_exc = 1'b1;
      st_next.redirect_valid = 1'b1;
      unique case (cls)
        CLS_ERROR: begin
          st_next.error_level_bit = 1'b1;
          st_next.error_restart_pc = restart_addr;
          st_next.redirect_pc = (code <= 5'(`PRI_NMI)) ? `RESET_VEC :
                                st_reg.exception_base_reg + `ERR_OFS;
          if (code == 5'(`PRI_COLD)) begin
            st_next.int_enable = 1'b0;
            st_next.user_mode_bit = 1'b0;
            st_next.debug_mode = 1'b0;
            st_next.exception_base_reg = `EXC_BASE_RST;
          end
        end
        CLS_DEBUG: begin
          st_next.debug_mode = 1'b1;
          st_next.debug_restart_pc = restart_addr;
          st_next.redirect_pc = `DEBUG_VEC;
          if (code == 5'(`PRI_DBG_IRQ)) st_next.debug_break_bit = 1'b0;
        end
        CLS_GENERAL: begin
          st_next.exception_level_bit = 1'b1;
          st_next.restart_pc = restart_addr;
          st_next.branch_delay_flag = wb_in_slot;
          st_next.cause_code = code;
          st_next.redirect_pc = st_reg.exception_base_reg + `GEN_OFS;
        end
      endcase
    end else if (wb_valid && wb_eret) begin
      st_next.redirect_valid = 1'b1;
      st_next.redirect_pc = st_reg.error_level_bit ?
                            st_reg.error_restart_pc :
                            st_reg.restart_pc;
      st_next.error_level_bit = 1'b0;
      if (!st_reg.error_level_bit) st_next.exception_level_bit = 1'b0;
    end else if (wb_valid && wb_deret) begin
      st_next.redirect_valid = 1'b1;
      st_next.redirect_pc = st_reg.debug_restart_pc;
      st_next.debug_mode = 1'b0;
    end
    // A software set of the break bit wins over its hardware clear
    if (wr && paddr == `OFS_DEBUG_CTRL && pwdata[`DC_BREAK]) begin
      st_next.debug_break_bit = 1'b1;
    end
    st_next.kernel_mode = !st_next.user_mode_bit ||
                          st_next.exception_level_bit ||
                          st_next.error_level_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign kill_mask = st_reg.kill_mask;
  assign stall_inhibit = st_reg.stall_inhibit;
  assign clear_exc = st_reg.clear_exc;
  assign redirect_valid = st_reg.redirect_valid;
  assign redirect_pc = st_reg.redirect_pc;
  assign exc_code = st_reg.cause_code;
  assign kernel_mode = st_reg.kernel_mode;
  assign debug_mode = st_reg.debug_mode;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_take;
    take;
  endsequence
  sequence s_commit;
    redirect_valid && clear_exc && kill_mask == 6'h3F;
  endsequence

  chk_commit_flush: assert property (s_take |=> s_commit)
    else $error("commit did not flush and redirect");
  chk_kill_older: assert property (
    (stage_exc_pending == 6'h04 && !take) |=> kill_mask == 6'h07)
    else $error("kill mask wrong for stage 2 fault");
  chk_cold_vector: assert property (
    cond[`PRI_COLD] |=> redirect_pc == `RESET_VEC &&
                       st_reg.error_level_bit && !kernel_mode == 1'b0)
    else $error("cold reset not vectored with error level");
  chk_nmi_edge_only: assert property (
    (!pin_rise[3] && !st_reg.nmi_pend) |=> !st_reg.nmi_pend)
    else $error("nmi pending without an edge");
  chk_prio_lower: assert property (
    take |-> (cond & ((24'h1 << code) - 24'h1)) == 24'h0 && cond[code])
    else $error("lower priority condition taken");
  chk_general_restart: assert property (
    (take && cls == CLS_GENERAL) |=>
      st_reg.exception_level_bit &&
      st_reg.restart_pc == $past(restart_addr) &&
      st_reg.branch_delay_flag == $past(wb_in_slot))
    else $error("general exception state not saved");
  chk_eret_levels: assert property (
    (wb_valid && wb_eret && !take && st_reg.error_level_bit) |=>
      !st_reg.error_level_bit &&
      st_reg.exception_level_bit == $past(st_reg.exception_level_bit) &&
      redirect_pc == $past(st_reg.error_restart_pc))
    else $error("return levels or target wrong");
  chk_debug_irq_take: assert property (
    (wb_valid && !st_reg.debug_mode && st_reg.debug_break_bit &&
     cond[2:0] == 3'h0) |-> take && code == 5'(`PRI_DBG_IRQ)
      ##1 redirect_pc == `DEBUG_VEC && debug_mode)
    else $error("debug break not taken as debug irq");
  chk_fetch_order: assert property (
    (wb_valid && wb_fetch_prot && cond[5:0] == 6'h00) |->
      code == 5'(`PRI_FETCH_PROT))
    else $error("fetch protection not first of fetch side");
endmodule

// File: shared/exc_map.svh
// Register offsets, field positions, reset values and vectors of the
// exception priority unit. Assumes inclusion by bare name.
`ifndef EXC_MAP_SVH
`define EXC_MAP_SVH

// APB register offsets (byte addresses)
`define OFS_STATUS 8'h00
`define OFS_CAUSE 8'h04
`define OFS_RESTART 8'h08
`define OFS_ERR_RESTART 8'h0C
`define OFS_DBG_RESTART 8'h10
`define OFS_EXC_BASE 8'h14
`define OFS_DEBUG_CTRL 8'h18
`define OFS_INT_MASK 8'h1C

// Status fields
`define ST_IE 0
`define ST_EXCL 1
`define ST_ERRL 2
`define ST_UM 4
`define ST_DEBUG 5
`define ST_KERNEL 6

// Cause fields
`define CA_CODE_LO 2
`define CA_SWINT_LO 8
`define CA_BDELAY 31

// Debug control fields
`define DC_BREAK 0
`define DC_STEP 1

// Condition indices, highest priority first
`define PRI_COLD 0
`define PRI_WARM 1
`define PRI_STEP 2
`define PRI_DBG_IRQ 3
`define PRI_NMI 4
`define PRI_INT 5
`define PRI_FETCH_PROT 6
`define PRI_INSTR_BRK 7
`define PRI_FETCH_ADDR 8
`define PRI_IMEM_PAR 9
`define PRI_IMEM_ECC 10
`define PRI_FETCH_BUS 11
`define PRI_COP_UNUSABLE 12
`define PRI_RESERVED 13
`define PRI_EXEC_PROT 14
`define PRI_DATA_PROT 15
`define PRI_DATA_BRK 16
`define PRI_LOAD_ADDR 17
`define PRI_STORE_ADDR 18
`define PRI_DMEM_PAR 19
`define PRI_DMEM_ECC 20
`define PRI_DATA_BUS 21
`define PRI_LOAD_BRK 22
`define PRI_COMPLEX_BRK 23
`define N_COND 24

// Vectors and reset values
`define RESET_VEC 32'hBFC0_0000
`define DEBUG_VEC 32'hBFC0_0480
`define GEN_OFS 32'h0000_0180
`define ERR_OFS 32'h0000_0100
`define EXC_BASE_RST 32'h8000_0000
`define INT_MASK_RST 8'h00

// Access sizes
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2

`endif

// File: shared/exc_pkg.sv
// Types of the exception priority unit.
// Assumes exc_map.svh is reachable on the include path.
`include "exc_map.svh"
package exc_pkg;

  typedef enum logic [2:0] {
    CLS_GENERAL = 3'b001,
    CLS_ERROR = 3'b010,
    CLS_DEBUG = 3'b100
  } exc_class_t;

  typedef logic [`N_COND-1:0] cond_vec_t;

  typedef struct packed {
    logic int_enable;
    logic exception_level_bit;
    logic error_level_bit;
    logic user_mode_bit;
    logic debug_mode;
    logic branch_delay_flag;
    logic [4:0] cause_code;
    logic [1:0] sw_int;
    logic [7:0] int_mask;
    logic debug_break_bit;
    logic single_step;
    logic nmi_pend;
    logic late_bus_err;
    logic [31:0] restart_pc;
    logic [31:0] error_restart_pc;
    logic [31:0] debug_restart_pc;
    logic [31:0] exception_base_reg;
    logic [5:0] kill_mask;
    logic stall_inhibit;
    logic clear_exc;
    logic redirect_valid;
    logic [31:0] redirect_pc;
    logic kernel_mode;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    error_level_bit: 1'b1,
    kernel_mode: 1'b1,
    int_mask: `INT_MASK_RST,
    exception_base_reg: `EXC_BASE_RST,
    default: '0
  };

endpackage

// File: hdl/exc_pin_sync.sv
// Two-flop synchroniser for asynchronous pins, with a rising-edge pulse.
// Assumes pins are unrelated to clk; rise is combinational from synced flops.
module exc_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and synchronised view
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
      prev_reg <= RST_VAL;
    end else begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
endmodule

// File: verif/pipe_model.sv
// Pipeline partner: keeps one valid instruction at writeback every cycle.
// Assumes the bench supplies pc, delay slot flag and the fault marker.
module pipe_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic [31:0] pc,
  input wire logic slot,
  input wire logic exc_on,
  input wire logic young,
  // Writeback view
  output logic wb_valid,
  output logic [31:0] wb_pc,
  output logic wb_in_slot,
  output logic [31:0] wb_branch_pc,
  output logic [5:0] stage_exc_pending
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clk or negedge rst_n) begin
    wb_valid <= rst_n;
  end
  assign wb_pc = pc;
  assign wb_in_slot = slot;
  // Branch sits one word before its slot; otherwise a changing garbage value
  assign wb_branch_pc = slot ? pc - 32'h4 : ~pc;
  // Oldest stage carries the fault, stage 2 a younger one
  assign stage_exc_pending = {exc_on, 2'b00, young, 2'b00};
endmodule

// File: verif/exception_priority_unit_bench.sv
// Self-checking bench of the exception priority unit.
// Assumes exc_pkg, exc_map.svh and pipe_model are compiled first.
`include "exc_map.svh"
module exception_priority_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] GEN = `EXC_BASE_RST + `GEN_OFS;
  localparam logic [31:0] ERR = `EXC_BASE_RST + `ERR_OFS;
  localparam int CODE [15] = '{6, 7, 9, 10, 11, 12, 12, 13, 15, 16, 19, 20,
                               21, 22, 23};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, redirect_pc, wb_pc, wb_branch_pc;
  logic [31:0] pc = 32'h0000_1000, wb_fetch_addr, wb_data_addr;
  logic pready, pslverr, stall_inhibit, clear_exc, redirect_valid;
  logic kernel_mode, debug_mode, wb_valid, wb_in_slot;
  logic cold_reset_in_n = 1, warm_reset_in_n = 1, nmi_in = 0, slot = 0;
  logic ext_debug_irq_in = 0, wb_eret = 0, wb_deret = 0, exc_on = 0;
  logic wb_is_load, wb_is_store, wb_exc_base_write, mpu_exc_base_deny;
  logic late_bus_error = 0, young = 0;
  logic [1:0] wb_data_size = `SZ_WORD;
  logic [3:0] xr = '0;
  logic [5:0] hw_int_in = '0, stage_exc_pending, kill_mask;
  logic [4:0] exc_code;
  logic [14:0] fl = '0;
  int mismatches = 0, compares = 0, cyc = 0;
  assign wb_fetch_addr = {pc[31:1], xr[0]};
  assign wb_is_load = xr[1];
  assign wb_is_store = xr[2];
  assign wb_data_addr = {pc[31:2], xr[1] | xr[2], 1'b0};
  assign wb_exc_base_write = xr[3];
  assign mpu_exc_base_deny = xr[3];
  always #2.5 pclk = ~pclk;
  exception_priority_unit u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cold_reset_in_n, .warm_reset_in_n, .nmi_in,
    .ext_debug_irq_in, .hw_int_in, .stage_exc_pending, .wb_valid, .wb_pc,
    .wb_in_slot, .wb_branch_pc, .wb_eret, .wb_deret,
    .wb_fetch_prot(fl[0]), .wb_debug_instr_break(fl[1]), .wb_fetch_addr,
    .wb_imem_parity(fl[2]), .wb_imem_ecc(fl[3]), .wb_fetch_bus_error(fl[4]),
    .wb_cop_unusable(fl[5]), .wb_dsp_disabled(fl[6]),
    .wb_reserved_instr(fl[7]), .wb_exc_base_write, .mpu_exc_base_deny,
    .wb_data_prot(fl[8]), .wb_debug_store_break(fl[9]), .wb_is_load,
    .wb_is_store, .wb_data_addr, .wb_data_size, .wb_dmem_parity(fl[10]),
    .wb_dmem_ecc(fl[11]), .wb_data_bus_error(fl[12]),
    .wb_debug_load_break(fl[13]), .wb_complex_breakpoint(fl[14]),
    .late_bus_error, .kill_mask, .stall_inhibit, .clear_exc, .redirect_valid,
    .redirect_pc, .exc_code, .kernel_mode, .debug_mode);
  pipe_model u_pipe (.clk(pclk), .rst_n(presetn), .pc, .slot, .exc_on,
    .wb_valid, .wb_pc, .wb_in_slot, .wb_branch_pc, .stage_exc_pending, .young);
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, logic [31:0] msk);
    logic [31:0] q;
    logic e;
    apb(0, a, 0, q, e);
    check("prdata", q & msk, exp);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1, a, d, q, e);
  endtask
  task automatic fire(logic [14:0] f, logic [3:0] x, logic [31:0] v, int c);
    @(posedge pclk);
    fl <= f;
    xr <= x;
    exc_on <= 1;
    @(posedge pclk);
    fl <= '0;
    xr <= '0;
    exc_on <= 0;
    @(posedge pclk);
    check("kill_mask", kill_mask, 6'h3F);
    check("stall_inhibit", stall_inhibit, 1);
    check("clear_exc", clear_exc, 1);
    check("kernel_mode", kernel_mode, 1);
    check("redirect_valid", redirect_valid, 1);
    check("redirect_pc", redirect_pc, v);
    if (c >= 0) check("exc_code", exc_code, c);
  endtask
  task automatic ret(logic dbg, logic [31:0] exp);
    @(posedge pclk);
    wb_eret <= !dbg;
    wb_deret <= dbg;
    @(posedge pclk);
    wb_eret <= 0;
    wb_deret <= 0;
    @(posedge pclk);
    check("return pc", redirect_pc, exp);
    check("debug_mode", debug_mode, 0);
  endtask
  task automatic wait_redir(logic [31:0] v);
    int n;
    n = 0;
    do @(posedge pclk); while (redirect_valid !== 1'b1 && ++n < 10);
    check("redirect_valid", redirect_valid, 1);
    check("redirect_pc", redirect_pc, v);
  endtask
  task automatic quiet;
    logic [31:0] k;
    k = 0;
    repeat (8) @(posedge pclk) k += redirect_valid;
    check("no redirect", k, 0);
  endtask
  task automatic younger_fault;
    young <= 1;
    @(posedge pclk);
    young <= 0;
    @(posedge pclk);
    check("kill_mask", kill_mask, 6'h07);
    check("stall_inhibit", stall_inhibit, 1);
    check("redirect_valid", redirect_valid, 0);
  endtask
  task automatic sweep;
    logic [31:0] v;
    for (int i = 0; i < 15; i++) begin
      v = CODE[i] inside {7, 16, 22, 23} ? `DEBUG_VEC :
          CODE[i] inside {9, 10, 19, 20} ? ERR : GEN;
      fire(15'h7FFF << i, 0, v, v == GEN ? CODE[i] : -1);
      rd(v == `DEBUG_VEC ? 8'h10 : v == GEN ? 8'h08 : 8'h0C, pc, '1);
      if (v == `DEBUG_VEC) ret(1, pc);
    end
  endtask
  task automatic pin_reset(logic cold);
    wr(`OFS_STATUS, 0);
    wr(`OFS_EXC_BASE, 32'h9000_0000);
    if (cold) cold_reset_in_n <= 0;
    else warm_reset_in_n <= 0;
    wait_redir(`RESET_VEC);
    cold_reset_in_n <= 1;
    warm_reset_in_n <= 1;
    repeat (4) @(posedge pclk);
    rd(`OFS_STATUS, 32'h4, 32'h4);
    rd(`OFS_EXC_BASE, cold ? `EXC_BASE_RST : 32'h9000_0000, '1);
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(`OFS_STATUS, 32'h44, 32'h77);
    rd(`OFS_EXC_BASE, `EXC_BASE_RST, '1);
    apb(0, 8'h40, 0, q, e);
    check("pslverr", e, 1);
    younger_fault;
    wr(`OFS_STATUS, 0);
    slot <= 1;
    fire(15'h0080, 0, GEN, 13);
    slot <= 0;
    rd(`OFS_RESTART, pc - 32'h4, '1);
    rd(`OFS_CAUSE, 32'h8000_0000, 32'h8000_0000);
    ret(0, pc - 32'h4);
    rd(`OFS_STATUS, 0, 32'h6);
    sweep;
    fire(15'h0080, 4'h1, GEN, 8);
    fire(0, 4'h2, GEN, 17);
    fire(0, 4'h4, GEN, 18);
    fire(15'h0100, 4'h8, GEN, 14);
    late_bus_error <= 1;
    @(posedge pclk);
    late_bus_error <= 0;
    wait_redir(GEN);
    check("exc_code", exc_code, 21);
    wr(`OFS_STATUS, 2);
    nmi_in <= 1;
    wait_redir(`RESET_VEC);
    quiet;
    nmi_in <= 0;
    rd(`OFS_STATUS, 32'h4, 32'h4);
    ret(0, pc);
    rd(`OFS_STATUS, 32'h2, 32'h6);
    ext_debug_irq_in <= 1;
    wait_redir(`DEBUG_VEC);
    ext_debug_irq_in <= 0;
    repeat (4) @(posedge pclk);
    ret(1, pc);
    wr(`OFS_DEBUG_CTRL, 32'h1);
    wait_redir(`DEBUG_VEC);
    ret(1, pc);
    wr(`OFS_STATUS, 1);
    wr(`OFS_INT_MASK, 0);
    hw_int_in <= 6'h01;
    quiet;
    wr(`OFS_INT_MASK, 32'h04);
    wait_redir(GEN);
    check("exc_code", exc_code, 5);
    hw_int_in <= 0;
    pin_reset(0);
    pin_reset(1);
    report_and_stop;
  end
endmodule
